/* rtl/sdd_consts.svh */
/*
  Constants for the sigma-delta decimator: sizes, reset values, counts.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef SDD_CONSTS_SVH
`define SDD_CONSTS_SVH

// Modulator samples per output word: 4.9152 MHz / 5 Hz
`define SDD_DECIM          983040
// Filter order, cascaded stages
`define SDD_ORDER          4
// Output words before a new value is fully settled
`define SDD_SETTLE_WORDS   4
// Output word period at nominal master clock, ms
`define SDD_WORD_PERIOD_MS 200
// Output words per display refresh (5 Hz / 2.5 Hz)
`define SDD_LCD_DIV        2
// Result word width
`define SDD_RES_W          24
// Segment image: 13 segment lines by 3 backplanes
`define SDD_SEG_W          39
// Result FIFO depth
`define SDD_FIFO_DEPTH     32
// Clock source after reset: internal oscillator
`define SDD_CLK_SEL_RST    1'b0

`endif

/* rtl/sdd_decim_top.sv */
/*
  Sigma-delta back end: clock source select, fourth-order sinc decimator,
  result FIFO with end-of-conversion flag, and display image refresh.
  Assumes the modulator bit, oscillator and external clock arrive as pins
  asynchronous to sys_clk_i, and each pin runs well below sys_clk_i / 4.
*/
// Overview of operation
// - Accept one-bit third-order modulator stream
// - Four cascaded moving sums of length N
// - Output settled after four word periods
// - Word rate equals first notch, 5Hz
// - Notches at integer multiples of word rate
// - Cutoff 0.228 of first notch frequency
// - Datapath holds 25% overrange without wrapping
// - Select 0 internal, 1 external clock
// - Clock select is 0 after reset
// - Rates scale with external clock frequency
// - Display refreshed at 2.5Hz nominal
// - Auto copy results or host drives display
// - Each segment individually host switchable
// - Active-low ready flag on stored result
`timescale 1ns/1ps
`include "sdd_consts.svh"
module sdd_decim_top
  import sdd_pkg::*;
#(
  parameter int DECIM      = `SDD_DECIM,
  parameter int RES_W      = `SDD_RES_W,
  parameter int SEG_W      = `SDD_SEG_W,
  parameter int FIFO_DEPTH = `SDD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // Pins from the analog side and clock sources
  input  wire logic             mod_bit_i,
  input  wire logic             int_osc_i,
  input  wire logic             ext_clk_i,
  // Configuration from the host port
  input  wire logic             clock_source_select_i,
  input  wire logic             auto_display_i,
  input  wire logic             seg_wr_i,
  input  wire logic [SEG_W-1:0] seg_data_i,
  input  wire logic             overrun_clr_i,
  // Result stream to the host port
  output logic                  res_valid_o,
  input  wire logic             res_ready_i,
  output logic      [RES_W-1:0] res_data_o,
  output logic                  eoc_n_o,
  output logic                  settled_o,
  output logic                  overrun_o,
  // Display driver side
  output logic      [SEG_W-1:0] lcd_seg_o,
  output logic                  lcd_update_o
);

  localparam int ORDER = `SDD_ORDER;
  // Sign plus a guard bit: with a power-of-two N, +N^4 would otherwise wrap
  localparam int ACC_W = ORDER * $clog2(DECIM) + 2;
  localparam int CNT_W = $clog2(DECIM);
  localparam int SHIFT = ACC_W - RES_W;

  initial begin
    if (DECIM < 2 || RES_W < 2 || RES_W > ACC_W || SEG_W < RES_W)
      $error("sdd_decim_top: unsupported DECIM, RES_W or SEG_W");
  end

  // Arithmetic right shift then cut to the result width
  function automatic logic [RES_W-1:0] scale_down(input logic [ACC_W-1:0] v);
    logic [ACC_W-1:0] s;
    s = ACC_W'($signed(v) >>> SHIFT);
    return s[RES_W-1:0];
  endfunction

  // Input synchronisers
  logic [1:0] osc_sync_q;
  logic [1:0] ext_sync_q;
  logic [1:0] bit_sync_q;
  logic [1:0] sel_sync_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      osc_sync_q <= '0;
      ext_sync_q <= '0;
      bit_sync_q <= '0;
      sel_sync_q <= '0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], int_osc_i};
      ext_sync_q <= {ext_sync_q[0], ext_clk_i};
      bit_sync_q <= {bit_sync_q[0], mod_bit_i};
      sel_sync_q <= {sel_sync_q[0], clock_source_select_i};
    end
  end

  // Clock source select
  logic clk_sel_q;
  logic src_level;
  logic src_prev_q;
  logic mod_edge;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk_sel_q <= `SDD_CLK_SEL_RST;
    end else begin
      clk_sel_q <= sel_sync_q[1];
    end
  end

  assign src_level = clk_sel_q ? ext_sync_q[1] : osc_sync_q[1];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  assign mod_edge = src_level && !src_prev_q;

  // Integrator cascade
  logic [ACC_W-1:0] integ_q [ORDER];
  logic [ACC_W-1:0] step;

  // Bit maps to plus or minus one
  assign step = bit_sync_q[1] ? ACC_W'(1) : {ACC_W{1'b1}};

  // Wide enough for N^4 at the comb output; the integrators wrap
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ORDER; i++) integ_q[i] <= '0;
    end else if (mod_edge) begin
      integ_q[0] <= integ_q[0] + step;
      for (int i = 1; i < ORDER; i++) integ_q[i] <= integ_q[i] + integ_q[i-1];
    end
  end

  // Decimation counter
  logic [CNT_W-1:0] dec_cnt_q;
  logic             word_stb;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dec_cnt_q <= '0;
    end else if (mod_edge) begin
      if (dec_cnt_q == CNT_W'(DECIM - 1)) dec_cnt_q <= '0;
      else dec_cnt_q <= dec_cnt_q + 1'b1;
    end
  end

  assign word_stb = mod_edge && (dec_cnt_q == CNT_W'(DECIM - 1));

  // Comb cascade at the low rate
  logic [ACC_W-1:0] comb_dly_q [ORDER];
  logic [ACC_W-1:0] comb      [ORDER+1];

  always_comb begin
    comb[0] = integ_q[ORDER-1];
    for (int i = 0; i < ORDER; i++) comb[i+1] = comb[i] - comb_dly_q[i];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ORDER; i++) comb_dly_q[i] <= '0;
    end else if (word_stb) begin
      for (int i = 0; i < ORDER; i++) comb_dly_q[i] <= comb[i];
    end
  end

  // Normalised word; the shift stands in for division by N^4
  logic [RES_W-1:0] result_q;
  logic             result_vld_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_q     <= '0;
      result_vld_q <= 1'b0;
    end else begin
      result_vld_q <= word_stb;
      if (word_stb) result_q <= scale_down(comb[ORDER]);
    end
  end

  // Settling tracker; a source change restarts it since the history is stale
  sdd_settle_e      settle_st_q;
  logic [2:0]       settle_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || (clk_sel_q != sel_sync_q[1])) begin
      settle_st_q  <= SDD_SETTLING;
      settle_cnt_q <= '0;
    end else if (result_vld_q) begin
      case (settle_st_q)
        SDD_SETTLING: begin
          settle_cnt_q <= settle_cnt_q + 1'b1;
          if (settle_cnt_q == 3'(`SDD_SETTLE_WORDS - 1)) settle_st_q <= SDD_SETTLED;
        end
        SDD_SETTLED: settle_st_q <= SDD_SETTLED;
        default:     settle_st_q <= SDD_SETTLING;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) settled_o <= 1'b0;
    else settled_o <= (settle_st_q == SDD_SETTLED);
  end

  // Result FIFO; the filter cannot pause, so a full FIFO drops the word
  logic fifo_ready;
  logic fifo_vld;

  sdd_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (result_vld_q),
    .in_ready_o  (fifo_ready),
    .in_data_i   (result_q),
    .out_valid_o (fifo_vld),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );

  assign res_valid_o = fifo_vld;

  // Overrun flag: a drop in the clearing cycle still sets it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) overrun_o <= 1'b0;
    else if (result_vld_q && !fifo_ready) overrun_o <= 1'b1;
    else if (overrun_clr_i) overrun_o <= 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) eoc_n_o <= 1'b1;
    else eoc_n_o <= !fifo_vld;
  end

  // Display image shadow and refresh pacing
  logic [SEG_W-1:0] shadow_q;
  logic             lcd_div_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shadow_q <= '0;
    end else if (auto_display_i && result_vld_q) begin
      shadow_q <= {{(SEG_W-RES_W){1'b0}}, result_q};
    end else if (!auto_display_i && seg_wr_i) begin
      shadow_q <= seg_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lcd_div_q    <= 1'b0;
      lcd_update_o <= 1'b0;
    end else begin
      lcd_update_o <= result_vld_q && lcd_div_q;
      if (result_vld_q) lcd_div_q <= !lcd_div_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) lcd_seg_o <= '0;
    else if (result_vld_q && lcd_div_q) lcd_seg_o <= shadow_q;
  end

  // Checks
  sequence word_out_s;
    word_stb ##1 result_vld_q;
  endsequence

  sequence refresh_s;
    (result_vld_q && lcd_div_q) ##1 lcd_update_o;
  endsequence

  clk_sel_rst_a: assert property (@(posedge sys_clk_i)
    $past(rst_i) |-> (clk_sel_q == 1'b0))
    else $error("clock select not internal after reset");

  clk_mux_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mod_edge |-> (clk_sel_q ? ext_sync_q[1] : osc_sync_q[1]) && !src_prev_q)
    else $error("sample edge not from selected source");

  integ_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    mod_edge |=> (integ_q[0] == $past(integ_q[0]) + $past(step))
              && (integ_q[1] == $past(integ_q[1]) + $past(integ_q[0])))
    else $error("integrator did not accumulate");

  decim_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    word_stb |=> (dec_cnt_q == '0) && !word_stb)
    else $error("decimation counter did not wrap");

  word_out_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    word_stb |-> word_out_s)
    else $error("output word not produced after decimation");

  settle_count_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(settled_o) |-> $past(settle_cnt_q) == 3'(`SDD_SETTLE_WORDS))
    else $error("settled before four words");

  eoc_store_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (result_vld_q && fifo_ready) |-> ##[1:3] !eoc_n_o)
    else $error("ready flag not low after store");

  lcd_rate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lcd_update_o |-> $past(result_vld_q) && $past(lcd_div_q))
    else $error("display refresh off the half word rate");

  lcd_pace_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (result_vld_q && lcd_div_q) |-> refresh_s)
    else $error("display refresh missed");

  auto_copy_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (auto_display_i && result_vld_q) |=> shadow_q[RES_W-1:0] == $past(result_q))
    else $error("result not copied to display image");

  host_seg_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!auto_display_i && seg_wr_i) |=> shadow_q == $past(seg_data_i))
    else $error("host segment write lost");

endmodule

/* rtl/sdd_fifo.sv */
/*
  Result FIFO with valid/ready on both sides; read data held in a register.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sdd_fifo
  import sdd_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("sdd_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_o = (count_q != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  // Output register refills when empty or being drained
  assign pop        = (count_q != '0) && (!out_valid_o || out_ready_i);

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_q[rd_ptr_q];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

  fifo_full_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (count_q == (AW+1)'(DEPTH)) |-> !in_ready_o)
    else $error("fifo accepts data while full");

endmodule

/* rtl/sdd_pkg.sv */
/*
  Types shared by the decimator files.
  Assumes nothing of its surroundings.
*/
package sdd_pkg;

  typedef enum logic [0:0] {
    SDD_SETTLING,
    SDD_SETTLED
  } sdd_settle_e;

endpackage

/* verif/sdd_host_model.sv */
/*
  Host-side model: takes result words from the decimator stream.
  Assumes one clock, synchronous active-high reset, and the bench for stalls.
*/
`timescale 1ns/1ps
module sdd_host_model (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Control from the bench
  input  wire logic        stall_i,
  // Result stream
  input  wire logic        res_valid_i,
  input  wire logic [23:0] res_data_i,
  output logic             res_ready_o,
  // Bookkeeping
  output logic [15:0]      word_cnt_o,
  output logic [23:0]      last_word_o
);
  // words are counted, the bench judges only settled ones
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      word_cnt_o  <= 16'h0;
      last_word_o <= 24'h0;
      res_ready_o <= #1 1'b0;
    end else begin
      if (res_valid_i && res_ready_o) begin
        word_cnt_o  <= word_cnt_o + 16'h1;
        last_word_o <= res_data_i;
      end
      // Ready moves just after the edge so a taken word is never half seen
      res_ready_o <= #1 !stall_i;
    end
  end
endmodule

/* verif/tb_top.sv */
/*
  Self-checking bench for the decimator top with a small decimation ratio.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import sdd_pkg::*;
  localparam int DECIM = 64;
  localparam int DEPTH = 32;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        mod_bit_i = 1'b0;
  logic        int_osc_i = 1'b0;
  logic        ext_clk_i = 1'b0;
  logic        sel       = 1'b0;
  logic        auto_disp = 1'b0;
  logic        seg_wr    = 1'b0;
  logic [38:0] seg_data  = 39'h0;
  logic        ovr_clr   = 1'b0;
  logic        stall     = 1'b0;
  logic        alt       = 1'b0;
  logic        pos_fs    = 1'b0;
  logic        res_valid, res_ready, eoc_n, settled, overrun, lcd_upd;
  logic [23:0] res_data, last_word;
  logic [38:0] lcd_seg;
  logic [15:0] words;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          d;

  sdd_decim_top #(.DECIM(DECIM), .RES_W(24), .SEG_W(39), .FIFO_DEPTH(DEPTH)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mod_bit_i(mod_bit_i),
    .int_osc_i(int_osc_i), .ext_clk_i(ext_clk_i), .clock_source_select_i(sel),
    .auto_display_i(auto_disp), .seg_wr_i(seg_wr), .seg_data_i(seg_data),
    .overrun_clr_i(ovr_clr), .res_valid_o(res_valid), .res_ready_i(res_ready),
    .res_data_o(res_data), .eoc_n_o(eoc_n), .settled_o(settled),
    .overrun_o(overrun), .lcd_seg_o(lcd_seg), .lcd_update_o(lcd_upd));

  sdd_host_model u_host (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall), .res_valid_i(res_valid),
    .res_data_i(res_data), .res_ready_o(res_ready), .word_cnt_o(words),
    .last_word_o(last_word));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Internal oscillator: 8 cycle period; alternating stream flips on its fall
  initial begin
    forever begin
      repeat (4) @(posedge sys_clk_i);
      #1 int_osc_i = ~int_osc_i;
      if (pos_fs) mod_bit_i = 1'b1;
      else if (alt && !int_osc_i) mod_bit_i = ~mod_bit_i;
    end
  end
  // external clock kept at 3 cycles high and low, inside the pin limit
  initial begin
    forever begin
      repeat (3) @(posedge sys_clk_i);
      #1 ext_clk_i = ~ext_clk_i;
    end
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    tick(12);
    rst_i = 1'b0;
  endtask
  task automatic wait_word();
    logic [15:0] n;
    n = words;
    for (int i = 0; i < 3000; i++) begin
      tick(1);
      if (words != n) return;
    end
    err_total++;
  endtask
  task automatic wait_upd();
    for (int i = 0; i < 3000; i++) begin
      tick(1);
      if (lcd_upd === 1'b1) return;
    end
    err_total++;
  endtask
  task automatic meas(output int dt);
    int t;
    wait_word();
    t = cycles;
    wait_word();
    dt = cycles - t;
  endtask

  task automatic t_reset();
    chk({res_valid, eoc_n, settled, overrun, lcd_upd}, 64'h08);
    chk(64'(lcd_seg), 64'h0);
  endtask
  task automatic t_neg_full();
    repeat (3) wait_word();
    chk(64'(settled), 64'h0);
    wait_word();
    tick(3);
    chk(64'(settled), 64'h1);
    wait_word();
    chk(64'(last_word), 64'hc00000);
  endtask
  task automatic t_rate();
    meas(d);
    chk(64'(d), 64'(DECIM * 8));
    sel = 1'b1;
    tick(6);
    chk(64'(settled), 64'h0);
    wait_word();
    meas(d);
    chk(64'(d), 64'(DECIM * 6));
    sel = 1'b0;
    repeat (6) wait_word();
  endtask
  task automatic t_disp();
    logic [15:0] n;
    seg_data = 39'h5a_a5c3_3c96;
    seg_wr   = 1'b1;
    tick(1);
    seg_wr = 1'b0;
    wait_upd();
    chk(64'(lcd_seg), 64'h5a_a5c3_3c96);
    n = words;
    wait_upd();
    chk(64'(words - n), 64'h2);
    auto_disp = 1'b1;
    seg_data  = 39'h12_3456_789a;
    seg_wr    = 1'b1;
    tick(1);
    seg_wr = 1'b0;
    wait_upd();
    wait_upd();
    chk(64'(lcd_seg), 64'hc0_0000);
    auto_disp = 1'b0;
  endtask
  task automatic t_overrun();
    logic [15:0] n;
    stall = 1'b1;
    for (int i = 0; i < 25000 && overrun !== 1'b1; i++) tick(1);
    chk(64'(overrun), 64'h1);
    chk(64'(eoc_n), 64'h0);
    n     = words;
    stall = 1'b0;
    tick(100);
    chk(64'(words - n), 64'(DEPTH + 1));
    chk({eoc_n, overrun}, 64'h3);
    ovr_clr = 1'b1;
    tick(1);
    ovr_clr = 1'b0;
    tick(2);
    chk(64'(overrun), 64'h0);
  endtask
  task automatic t_alt();
    alt = 1'b1;
    do_reset();
    repeat (6) wait_word();
    chk(64'(last_word), 64'h0);
    alt    = 1'b0;
    pos_fs = 1'b1;
    repeat (6) wait_word();
    chk(64'(last_word), 64'h40_0000);
  endtask

  initial begin
    do_reset();
    tick(1);
    t_reset();
    t_neg_full();
    t_rate();
    t_disp();
    t_overrun();
    t_alt();
    finish_test();
  end
endmodule
